// [src/lpw_ctrl.sv]
// Low-power mode and wake-up sequencer: run, stop, standby, battery.
// Assumes pins are asynchronous and pass the synchroniser; requests from
// the core are on SYS_CLK. Backup supply switch is driven by this block.
//
// Summary of operation
// - Stop keeps regulator normal or low-power.
// - Calendar and low-power timer keep running in stop.
// - Any external interrupt line wakes from stop.
// - Standby switches off regulator and core domain.
// - Standby stops PLL and both oscillators.
// - Standby loses SRAM; backup kept if selected.
// - Reset pin, watchdog, wake rise, calendar exit standby.
// - No standby when regulator is bypassed.
// - Battery operation when main supply absent and internal reset enabled.
// - Battery keeps only backup registers; calendar and timer stop (CAL_LPTIM_RUN low).
// - Interrupts and calendar never leave battery operation.
// - Internal reset disabled means no battery switching.
`timescale 1ns/1ps
module lpw_ctrl
  import lpw_pkg::*;
#(
  parameter int LINES = lpw_pkg::EXT_LINES
) (
  input  wire logic             SYS_CLK,
  input  wire logic             SRST,
  input  wire logic             STOP_REQ,
  input  wire logic             STANDBY_REQ,
  input  wire logic             STOP_REG_LOWPOWER,
  input  wire logic             BACKUP_RETAIN_SEL,
  input  wire logic             REG_BYPASS,
  input  wire logic [LINES-1:0] EXT_LINE_EVT,
  input  wire logic             SUPPLY_DET_EVT,
  input  wire logic             LP_TIMER_EVT,
  input  wire logic             CAL_EVT,
  input  wire logic             WDG_RESET,
  input  wire logic             EXT_RESET_PIN_N,
  input  wire logic             WAKEUP_PIN,
  input  wire logic             MAIN_SUPPLY_OK,
  input  wire logic             INT_RESET_EN_PIN,
  output logic                  REG_ON,
  output logic                  REG_LOWPOWER,
  output logic                  CORE_PWR_ON,
  output logic                  PLL_EN,
  output logic                  RC_OSC_EN,
  output logic                  XTAL_OSC_EN,
  output logic                  CORE_CLK_EN,
  output logic                  CAL_LPTIM_RUN,
  output logic                  SRAM_LOST,
  output logic                  BACKUP_RETAIN,
  output logic                  BATT_MODE,
  output logic                  BATT_AVAILABLE,
  output logic                  CORE_RESET,
  output logic [2:0]            POWER_STATE
);
  import lpw_pkg::*;

  // ************************************************************
  // Synchronised pins
  // ************************************************************
  localparam int NPIN = LINES + 8;

  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_syn;
  logic [LINES-1:0] line_s;
  logic            supdet_s;
  logic            lptim_s;
  logic            cal_s;
  logic            wdg_s;
  logic            rstpin_n_s;
  logic            wakeup_pin_s;
  logic            main_ok_s;
  logic            porst_en_s;
  logic            wakeup_pin_d_reg;
  logic            wakeup_pin_rise;
  logic            stop_wake;
  logic            sb_wake;
  logic            batt_ok;
  logic [7:0]      settle_reg;
  lpw_state_t      state_reg;
  lpw_state_t      state_next;

  assign pin_raw = {EXT_LINE_EVT, SUPPLY_DET_EVT, LP_TIMER_EVT, CAL_EVT, WDG_RESET,
                    EXT_RESET_PIN_N, WAKEUP_PIN, MAIN_SUPPLY_OK, INT_RESET_EN_PIN};

  lpw_sync #(
    .WIDTH (NPIN)
  ) u_sync (
    .clk  (SYS_CLK),
    .rst  (SRST),
    .din  (pin_raw),
    .dout (pin_syn)
  );

  assign line_s     = pin_syn[NPIN-1:8];
  assign supdet_s   = pin_syn[7];
  assign lptim_s    = pin_syn[6];
  assign cal_s      = pin_syn[5];
  assign wdg_s      = pin_syn[4];
  assign rstpin_n_s = pin_syn[3];
  assign wakeup_pin_s     = pin_syn[2];
  assign main_ok_s  = pin_syn[1];
  assign porst_en_s = pin_syn[0];

  // ************************************************************
  // Wake sources
  // ************************************************************
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
      wakeup_pin_d_reg <= 1'b0;
    else
      wakeup_pin_d_reg <= wakeup_pin_s;
  end

  assign wakeup_pin_rise = wakeup_pin_s & ~wakeup_pin_d_reg;
  // Any external interrupt line source
  assign stop_wake = (|line_s) | supdet_s | lptim_s | cal_s;
  // Standby exit sources
  assign sb_wake   = ~rstpin_n_s | wdg_s | wakeup_pin_rise | cal_s;
  // Switching needs the internal reset supervisor
  assign batt_ok   = porst_en_s;

  // ************************************************************
  // State sequencing
  // ************************************************************
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      LPW_RUN:
      begin
        // Wake sources are not looked at here
        if (!main_ok_s && batt_ok)
          state_next = LPW_BATTERY;
        else if (STANDBY_REQ && !REG_BYPASS)
          state_next = LPW_SB_ENTRY;
        else if (STOP_REQ)
          state_next = LPW_STOP;
      end
      LPW_STOP:
      begin
        if (!main_ok_s && batt_ok)
          state_next = LPW_BATTERY;
        else if (stop_wake)
          state_next = LPW_RUN;
      end
      LPW_SB_ENTRY:
      begin
        if (settle_reg == 8'h00)
          state_next = LPW_STANDBY;
      end
      LPW_STANDBY:
      begin
        if (!main_ok_s && batt_ok)
          state_next = LPW_BATTERY;
        else if (sb_wake)
          state_next = LPW_RUN;
      end
      LPW_BATTERY:
      begin
        // Return of main supply or loss of the internal reset enable ends battery operation
        if (main_ok_s || !batt_ok)
          state_next = LPW_RUN;
      end
      default:
        state_next = LPW_RUN;
    endcase
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
      state_reg <= LPW_RUN;
    else
      state_reg <= state_next;
  end

  // Short settle lets the core quiesce before power is cut
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
      settle_reg <= SETTLE_CNT_INIT;
    else if (state_reg != LPW_SB_ENTRY)
      settle_reg <= SETTLE_CNT_INIT;
    else if (settle_reg != 8'h00)
      settle_reg <= settle_reg - 8'h01;
  end

  // ************************************************************
  // Power and clock outputs
  // ************************************************************
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      REG_ON       <= REG_ON_RST;
      REG_LOWPOWER <= REG_LP_RST;
      CORE_PWR_ON  <= REG_ON_RST;
    end
    else
    begin
      REG_ON       <= !(state_next inside {LPW_STANDBY, LPW_BATTERY});
      REG_LOWPOWER <= (state_next == LPW_STOP) && STOP_REG_LOWPOWER;
      CORE_PWR_ON  <= !(state_next inside {LPW_STANDBY, LPW_BATTERY});
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      PLL_EN      <= OSC_ON_RST;
      RC_OSC_EN   <= OSC_ON_RST;
      XTAL_OSC_EN <= OSC_ON_RST;
      CORE_CLK_EN <= OSC_ON_RST;
    end
    else
    begin
      // Stop also halts the high-speed clocks
      PLL_EN      <= (state_next == LPW_RUN) || (state_next == LPW_SB_ENTRY);
      RC_OSC_EN   <= (state_next == LPW_RUN) || (state_next == LPW_SB_ENTRY);
      XTAL_OSC_EN <= (state_next == LPW_RUN) || (state_next == LPW_SB_ENTRY);
      CORE_CLK_EN <= (state_next == LPW_RUN);
    end
  end

  // Calendar and timer run in every state but battery, where CAL_LPTIM_RUN is low
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
      CAL_LPTIM_RUN <= 1'b1;
    else
      CAL_LPTIM_RUN <= (state_next != LPW_BATTERY);
  end

  // ************************************************************
  // Retention and reset
  // ************************************************************
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      SRAM_LOST     <= 1'b0;
      BACKUP_RETAIN <= 1'b0;
      CORE_RESET    <= 1'b0;
    end
    else
    begin
      // Lost-contents flag stands until the run state holds for a second cycle
      if (state_next == LPW_STANDBY)
        SRAM_LOST <= 1'b1;
      else if (state_next == LPW_RUN && state_reg == LPW_RUN)
        SRAM_LOST <= 1'b0;
      if (state_reg == LPW_RUN)
        BACKUP_RETAIN <= BACKUP_RETAIN_SEL;
      // Core restarts from reset after standby or battery, one cycle
      CORE_RESET <= (state_reg inside {LPW_STANDBY, LPW_BATTERY}) && (state_next == LPW_RUN);
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      BATT_MODE      <= BATT_RST;
      BATT_AVAILABLE <= 1'b0;
      POWER_STATE    <= 3'h0;
    end
    else
    begin
      BATT_MODE      <= (state_next == LPW_BATTERY);
      BATT_AVAILABLE <= batt_ok;
      POWER_STATE    <= state_next;
    end
  end

endmodule

// [src/lpw_pkg.sv]
// Package for the low-power mode and wake-up controller.
// Assumes one 100 MHz system clock and a synchronous active-high reset.
package lpw_pkg;

  // ************************************************************
  // Sizes and counts
  // ************************************************************
  localparam int          EXT_LINES      = 16;
  localparam int          SYNC_STAGES    = 3;
  localparam int          CLK_PERIOD_NS  = 10;
  // Settling time before the regulator is cut on standby entry
  localparam int          ENTRY_SETTLE_NS = 100;
  localparam int          ENTRY_SETTLE_CYC =
    (ENTRY_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  SETTLE_CNT_INIT = 8'(ENTRY_SETTLE_CYC);

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic        REG_ON_RST     = 1'b1;
  localparam logic        REG_LP_RST     = 1'b0;
  localparam logic        OSC_ON_RST     = 1'b1;
  localparam logic        BATT_RST       = 1'b0;

  // ************************************************************
  // Power states
  // ************************************************************
  typedef enum logic [2:0]
  {
    LPW_RUN,
    LPW_STOP,
    LPW_SB_ENTRY,
    LPW_STANDBY,
    LPW_BATTERY
  } lpw_state_t;

endpackage

// [src/lpw_sync.sv]
// Three-stage input synchroniser with agreement filter.
// Assumes the input is asynchronous to the clock.
`timescale 1ns/1ps
module lpw_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  import lpw_pkg::*;

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;

  // ************************************************************
  // Stages; first stage feeds only the second
  // ************************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end
    else
    begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // A change counts once stages two and three agree
  always_ff @(posedge clk)
  begin
    if (rst)
      dout <= '0;
    else
    begin
      for (int i = 0; i < WIDTH; i++)
      begin
        if (s2_reg[i] == s3_reg[i])
          dout[i] <= s3_reg[i];
      end
    end
  end

endmodule

// [tb/lpw_ctrl_properties.sv]
// Port checker for the low-power sequencer.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module lpw_ctrl_properties (
  input wire logic       SYS_CLK,
  input wire logic       SRST,
  input wire logic       STOP_REQ,
  input wire logic       STANDBY_REQ,
  input wire logic       STOP_REG_LOWPOWER,
  input wire logic       REG_BYPASS,
  input wire logic       REG_ON,
  input wire logic       REG_LOWPOWER,
  input wire logic       CORE_PWR_ON,
  input wire logic       PLL_EN,
  input wire logic       RC_OSC_EN,
  input wire logic       XTAL_OSC_EN,
  input wire logic       CAL_LPTIM_RUN,
  input wire logic       SRAM_LOST,
  input wire logic       BATT_MODE,
  input wire logic       CORE_RESET,
  input wire logic [2:0] POWER_STATE
);
  // ********************
  // State relations
  // ********************
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SRST);
  stop_lp_a: assert property (POWER_STATE == 3'h1 && $past(POWER_STATE) == 3'h0
    |-> REG_LOWPOWER == $past(STOP_REG_LOWPOWER)) else $error("stop regulator mode");
  stop_cal_a: assert property (POWER_STATE == 3'h1 |-> CAL_LPTIM_RUN)
    else $error("calendar stopped in stop");
  sb_power_a: assert property (POWER_STATE == 3'h3 |-> !REG_ON && !CORE_PWR_ON)
    else $error("core powered in standby");
  sb_clocks_a: assert property (POWER_STATE == 3'h3 |-> !(PLL_EN || RC_OSC_EN || XTAL_OSC_EN))
    else $error("clock source on in standby");
  sb_sram_a: assert property (POWER_STATE == 3'h3 |-> SRAM_LOST)
    else $error("memory loss not flagged");
  bypass_sb_a: assert property (POWER_STATE == 3'h0 && REG_BYPASS |=> POWER_STATE != 3'h2)
    else $error("standby taken while bypassed");
  batt_flag_a: assert property (BATT_MODE == (POWER_STATE == 3'h4))
    else $error("battery flag wrong");
  batt_hold_a: assert property (POWER_STATE == 3'h4 |=> POWER_STATE inside {3'h0, 3'h4})
    else $error("battery left for a low-power state");
  run_quiet_a: assert property (POWER_STATE == 3'h0 && !STOP_REQ && !STANDBY_REQ
    |=> POWER_STATE inside {3'h0, 3'h4}) else $error("run left without request");
  core_rst_a: assert property (POWER_STATE == 3'h0 && $past(POWER_STATE) inside {3'h3, 3'h4}
    |-> CORE_RESET) else $error("no core reset after standby");
  stop_c: cover property (POWER_STATE == 3'h1);
  sb_c: cover property (POWER_STATE == 3'h3);
  batt_c: cover property (POWER_STATE == 3'h4);
endmodule

// [tb/lpw_far.sv]
// Model of the pins, supply monitor and calendar events.
// Assumes the bench calls its tasks one at a time.
`timescale 1ns/1ps
module lpw_far (
  input  wire logic        clk,
  output logic      [15:0] lines,
  output logic             sup,
  output logic             lpt,
  output logic             cal,
  output logic             wdg,
  output logic             rst_n,
  output logic             wake,
  output logic             ok,
  output logic             ren
);
  // ********************
  // Event pulses
  // ********************
  // Bits 15:0 lines, 16 detector, 17 timer, 18 calendar, 19 watchdog, 20 wake, 21 reset
  logic [21:0] ev_reg = 22'h0;
  logic        ok_reg = 1'b1;
  logic        ren_reg = 1'b1;
  assign lines = ev_reg[15:0];
  assign sup = ev_reg[16];
  assign lpt = ev_reg[17];
  assign cal = ev_reg[18];
  assign wdg = ev_reg[19];
  assign wake = ev_reg[20];
  assign rst_n = ~ev_reg[21];
  assign ok = ok_reg;
  assign ren = ren_reg;
  // Eight cycles outlast the three-stage synchroniser and its agree flop
  task pulse(input int i);
    @(posedge clk);
    ev_reg[i] <= 1'b1;
    repeat (8) @(posedge clk);
    ev_reg[i] <= 1'b0;
    // Let the falling level clear the synchroniser so the next entry is not woken at once
    repeat (6) @(posedge clk);
  endtask
  task supply(input logic o, input logic r);
    @(posedge clk);
    ok_reg <= o;
    ren_reg <= r;
  endtask
endmodule

// [tb/lpw_ctrl_bench.sv]
// Self-checking bench for the low-power sequencer.
// Assumes lpw_far drives every asynchronous pin.
`timescale 1ns/1ps
module lpw_ctrl_bench;
  import lpw_pkg::*;
  // ********************
  // Wiring
  // ********************
  logic clk = 1'b0, rst = 1'b1, stp = 1'b0, sby = 1'b0, lp = 1'b0, ret = 1'b1, byp = 1'b0;
  logic reg_on, reg_lp, cpw, pll, rc, xt, cke, cal, lost, bkr, bat, bav;
  logic sup, lpt, cev, wdg, rsn, wk, ok, ren;
  logic [15:0] ln;
  logic [2:0] st;
  int errors = 0, total_checks = 0, n;
  always #5 clk = ~clk;
  lpw_far far_u (.clk(clk), .lines(ln), .sup(sup), .lpt(lpt), .cal(cev), .wdg(wdg),
    .rst_n(rsn), .wake(wk), .ok(ok), .ren(ren));
  lpw_ctrl dut_u (.SYS_CLK(clk), .SRST(rst), .STOP_REQ(stp), .STANDBY_REQ(sby),
    .STOP_REG_LOWPOWER(lp), .BACKUP_RETAIN_SEL(ret), .REG_BYPASS(byp), .EXT_LINE_EVT(ln),
    .SUPPLY_DET_EVT(sup), .LP_TIMER_EVT(lpt), .CAL_EVT(cev), .WDG_RESET(wdg),
    .EXT_RESET_PIN_N(rsn), .WAKEUP_PIN(wk), .MAIN_SUPPLY_OK(ok), .INT_RESET_EN_PIN(ren),
    .REG_ON(reg_on), .REG_LOWPOWER(reg_lp), .CORE_PWR_ON(cpw), .PLL_EN(pll), .RC_OSC_EN(rc),
    .XTAL_OSC_EN(xt), .CORE_CLK_EN(cke), .CAL_LPTIM_RUN(cal), .SRAM_LOST(lost),
    .BACKUP_RETAIN(bkr), .BATT_MODE(bat), .BATT_AVAILABLE(bav), .CORE_RESET(), .POWER_STATE(st));
  // ********************
  // Shared tasks
  // ********************
  task complete_run();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task check(input string nm, input logic [2:0] exp, input logic [2:0] got);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  // Bounded wait; a stuck state ends the run
  task wait_st(input logic [2:0] s);
    n = 0;
    while (st !== s && n < 40)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    check("state", s, st);
    if (st !== s)
      complete_run();
  endtask
  task req(input logic s, input logic m);
    @(posedge clk);
    stp <= !s;
    sby <= s;
    lp <= m;
    @(posedge clk);
    stp <= 1'b0;
    sby <= 1'b0;
  endtask
  // ********************
  // Scenarios
  // ********************
  task t_stop(input int src, input logic m);
    req(1'b0, m);
    wait_st(3'h1);
    check("reg_lp", {2'h0, m}, {2'h0, reg_lp});
    check("cal_run", 3'h1, {2'h0, cal});
    check("clocks", 3'h0, {pll, xt, cke});
    far_u.pulse(src);
    wait_st(3'h0);
    check("run_clk", 3'h7, {pll, rc, cke});
    $display("stop wake %0d done", src);
  endtask
  task t_sby(input int src);
    req(1'b1, 1'b0);
    wait_st(3'h3);
    check("sb_pwr", 3'h0, {reg_on, cpw, 1'b0});
    check("sb_osc", 3'h0, {pll, rc, xt});
    check("sb_mem", 3'h3, {1'b0, lost, bkr});
    far_u.pulse(src);
    wait_st(3'h0);
    check("sb_on", 3'h7, {reg_on, cpw, rc});
    $display("standby wake %0d done", src);
  endtask
  task t_byp();
    @(posedge clk);
    byp <= 1'b1;
    req(1'b1, 1'b0);
    far_u.pulse(3);
    #1;
    check("bypass", 3'h0, st);
    @(posedge clk);
    byp <= 1'b0;
    $display("bypass done");
  endtask
  task t_batt();
    far_u.supply(1'b0, 1'b1);
    wait_st(3'h4);
    check("batt", 3'h4, {bat, pll, cal});
    far_u.pulse(7);
    far_u.pulse(18);
    #1;
    check("batt_hold", 3'h4, st);
    far_u.supply(1'b1, 1'b1);
    wait_st(3'h0);
    far_u.supply(1'b0, 1'b0);
    repeat (10) @(posedge clk);
    #1;
    check("no_batt", 3'h0, {bat, st[2], bav});
    far_u.supply(1'b1, 1'b1);
    repeat (6) @(posedge clk);
    $display("battery done");
  endtask
  // ********************
  // Main sequence
  // ********************
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    t_stop(0, 1'b1);
    t_stop(15, 1'b0);
    t_stop(16, 1'b1);
    t_stop(17, 1'b0);
    t_stop(18, 1'b1);
    t_sby(20);
    t_sby(19);
    t_sby(21);
    t_sby(18);
    t_byp();
    t_batt();
    complete_run();
  end
endmodule
bind lpw_ctrl lpw_ctrl_properties chk_u (.SYS_CLK(SYS_CLK), .SRST(SRST), .STOP_REQ(STOP_REQ),
  .STANDBY_REQ(STANDBY_REQ), .STOP_REG_LOWPOWER(STOP_REG_LOWPOWER), .REG_BYPASS(REG_BYPASS),
  .REG_ON(REG_ON), .REG_LOWPOWER(REG_LOWPOWER), .CORE_PWR_ON(CORE_PWR_ON), .PLL_EN(PLL_EN),
  .RC_OSC_EN(RC_OSC_EN), .XTAL_OSC_EN(XTAL_OSC_EN), .CAL_LPTIM_RUN(CAL_LPTIM_RUN),
  .SRAM_LOST(SRAM_LOST), .BATT_MODE(BATT_MODE), .CORE_RESET(CORE_RESET), .POWER_STATE(POWER_STATE));
